// file: logic/chan_svc_pkg.sv
// shared constants and types for the flow delete and channel move logic
package chan_svc_pkg;
	localparam int unsigned CLOCK_HZ          = 100_000_000;
	localparam int unsigned TICK_MS           = 1;
	localparam int unsigned TICK_CYCLES       = CLOCK_HZ / 1000 * TICK_MS;
	localparam int unsigned TICK_W            = 17;
	localparam int unsigned OLD_HOLD_MS       = 1000;
	localparam int unsigned NEW_HOLD_MIN_MS   = 2000;
	localparam int unsigned NEW_HOLD_MAX_MS   = 35000;
	localparam int unsigned JUMP_DEFAULT_MS   = 1300;
	localparam int unsigned MS_W              = 16;
	localparam int unsigned FLOW_W            = 16;
	localparam logic [15:0] FLOW_NONE         = 16'h0000;

	// initialization technique carried by a channel move request
	typedef enum logic [1:0] {
		INIT_REINIT  = 2'h0,
		INIT_RANGE   = 2'h1,
		INIT_DIRECT  = 2'h2,
		INIT_INITIAL = 2'h3
	} init_tech_e;

	// message kinds on the link
	typedef enum logic [2:0] {
		MSG_NONE        = 3'h0,
		MSG_DEL_REQ     = 3'h1,
		MSG_DEL_RSP     = 3'h2,
		MSG_MOVE_REQ    = 3'h3,
		MSG_MOVE_DEPART = 3'h4,
		MSG_MOVE_ARRIVE = 3'h5,
		MSG_RANGE_ABORT = 3'h6
	} msg_e;

	// one message word on the link
	typedef struct packed {
		msg_e               kind;
		logic [FLOW_W-1:0]  up_flow;
		logic [FLOW_W-1:0]  dn_flow;
		logic               move_up;
		logic               move_dn;
		logic               tech_present;
		init_tech_e         tech;
		logic               jump_present;
		logic [MS_W-1:0]    jump_ms;
	} msg_s;
endpackage

// file: logic/chan_svc_if.sv
// link between subscriber modem end and headend terminal end
`timescale 1ns/10ps
`default_nettype none
interface chan_svc_if;
	chan_svc_pkg::msg_s up_msg;
	logic               up_valid;
	chan_svc_pkg::msg_s dn_msg;
	logic               dn_valid;

	modport modem
	(
		output up_msg,
		output up_valid,
		input  dn_msg,
		input  dn_valid
	);
	modport headend
	(
		input  up_msg,
		input  up_valid,
		output dn_msg,
		output dn_valid
	);
endinterface
`default_nettype wire

// file: logic/subscriber_modem_ctl.sv
// subscriber modem end: flow delete and channel move control
`timescale 1ns/10ps
`default_nettype none
module subscriber_modem_ctl
(
	input  wire logic                             clock,
	input  wire logic                             reset,
	chan_svc_if.modem                             link,
	input  wire logic                             del_valid,
	output logic                                  del_ready,
	input  wire logic [chan_svc_pkg::FLOW_W-1:0]  del_up_flow,
	input  wire logic [chan_svc_pkg::FLOW_W-1:0]  del_dn_flow,
	output logic                                  flow_remove,
	output logic [chan_svc_pkg::FLOW_W-1:0]       flow_remove_up,
	output logic [chan_svc_pkg::FLOW_W-1:0]       flow_remove_dn,
	output logic                                  del_done,
	input  wire logic                             sync_done,
	output logic                                  tune_start,
	output logic                                  use_old,
	output logic                                  do_reinit,
	output logic                                  do_range,
	output logic                                  bw_void,
	output logic                                  move_busy
);
	// gray along idle, depart, tune, sync and back to idle
	typedef enum logic [2:0] {
		IDLE      = 3'h0,
		MV_DEPART = 3'h1,
		MV_TUNE   = 3'h3,
		MV_SYNC   = 3'h2,
		DEL_WAIT  = 3'h4
	} state_e;

	typedef struct packed {
		state_e                           st;
		chan_svc_pkg::msg_s               out;
		logic                             out_v;
		chan_svc_pkg::msg_s               req;
		logic [chan_svc_pkg::TICK_W-1:0]  tick_cnt;
		logic [chan_svc_pkg::MS_W-1:0]    hold_ms;
		logic                             rm;
		logic [chan_svc_pkg::FLOW_W-1:0]  rm_up;
		logic [chan_svc_pkg::FLOW_W-1:0]  rm_dn;
		logic                             done;
		logic                             tune;
		logic                             reinit;
		logic                             range;
		logic                             bwv;
	} state_s;

	state_s s_q;
	state_s s_d;
	logic   tick;

	// kind test of a downstream message, shared by every decode below
	function automatic logic dn_is
	(
		input logic                valid,
		input chan_svc_pkg::msg_s  m,
		input chan_svc_pkg::msg_e  want
	);
		return valid && (m.kind == want);
	endfunction

	// the headend side is same-clock logic, so no synchroniser
	always_comb
	begin
		s_d        = s_q;
		s_d.out_v  = 1'b0;
		s_d.rm     = 1'b0;
		s_d.done   = 1'b0;
		s_d.tune   = 1'b0;
		s_d.reinit = 1'b0;
		s_d.range  = 1'b0;
		s_d.bwv    = 1'b0;
		tick       = (s_q.tick_cnt == chan_svc_pkg::TICK_W'(chan_svc_pkg::TICK_CYCLES - 1));
		s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + 1'b1;
		if (tick && s_q.hold_ms != '0)
			s_d.hold_ms = s_q.hold_ms - 1'b1;
		// headend delete request is served in any state: remove and answer in the same cycle
		if (dn_is(link.dn_valid, link.dn_msg, chan_svc_pkg::MSG_DEL_REQ))
		begin
			s_d.rm          = 1'b1;
			s_d.rm_up       = link.dn_msg.up_flow;
			s_d.rm_dn       = link.dn_msg.dn_flow;
			s_d.out         = link.dn_msg;
			s_d.out.kind    = chan_svc_pkg::MSG_DEL_RSP;
			s_d.out_v       = 1'b1;
		end
		case (s_q.st)
			IDLE:
			begin
				if (dn_is(link.dn_valid, link.dn_msg,
					chan_svc_pkg::MSG_MOVE_REQ))
				begin
					s_d.req     = link.dn_msg;
					s_d.hold_ms = chan_svc_pkg::MS_W'(chan_svc_pkg::OLD_HOLD_MS);
					s_d.st      = MV_DEPART;
				end
				// same condition as del_ready, so a shown refusal holds
				else if (del_valid && !link.dn_valid)
				begin
					// flow removed locally in the same cycle the request leaves
					s_d.rm            = 1'b1;
					s_d.rm_up         = del_up_flow;
					s_d.rm_dn         = del_dn_flow;
					s_d.out           = '0;
					s_d.out.kind      = chan_svc_pkg::MSG_DEL_REQ;
					s_d.out.up_flow   = del_up_flow;
					s_d.out.dn_flow   = del_dn_flow;
					s_d.out_v         = 1'b1;
					s_d.st            = DEL_WAIT;
				end
			end
			DEL_WAIT:
				if (dn_is(link.dn_valid, link.dn_msg,
					chan_svc_pkg::MSG_DEL_RSP))
				begin
					s_d.done = 1'b1;
					s_d.st   = IDLE;
				end
			MV_DEPART:
				if (!s_d.out_v)
				begin
					// depart carries a jump time of zero: jump right away
					s_d.out              = s_q.req;
					s_d.out.kind         = chan_svc_pkg::MSG_MOVE_DEPART;
					s_d.out.jump_present = 1'b1;
					s_d.out.jump_ms      = '0;
					s_d.out_v            = 1'b1;
					s_d.st               = MV_TUNE;
				end
			MV_TUNE:
			begin
				// jump well before the old hold time expires
				s_d.tune = 1'b1;
				s_d.st   = MV_SYNC;
			end
			MV_SYNC:
				if (sync_done)
				begin
					s_d.bwv = 1'b1;
					s_d.st  = IDLE;
					if (!s_q.req.tech_present || s_q.req.tech == chan_svc_pkg::INIT_REINIT)
						s_d.reinit = 1'b1;
					else
					begin
						s_d.range = (s_q.req.tech != chan_svc_pkg::INIT_DIRECT);
						// limitation: a delete answer here wins, arrive is lost
						if (!s_d.out_v)
						begin
							s_d.out      = s_q.req;
							s_d.out.kind = chan_svc_pkg::MSG_MOVE_ARRIVE;
							s_d.out_v    = 1'b1;
						end
					end
				end
			default:
				s_d.st = IDLE;
		endcase
	end

	// one register for the whole state; reset clears every field
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// outputs
	// refused while any downstream message lands, it may start a move
	assign del_ready      = (s_q.st == IDLE) && !(link.dn_valid);
	assign link.up_msg    = s_q.out;
	assign link.up_valid  = s_q.out_v;
	assign flow_remove    = s_q.rm;
	assign flow_remove_up = s_q.rm_up;
	assign flow_remove_dn = s_q.rm_dn;
	assign del_done       = s_q.done;
	assign tune_start     = s_q.tune;
	// old channel only while its hold time is still running
	assign use_old        = ((s_q.st == MV_DEPART) || (s_q.st == MV_TUNE))
		&& (s_q.hold_ms != '0);
	assign do_reinit      = s_q.reinit;
	assign do_range       = s_q.range;
	assign bw_void        = s_q.bwv;
	assign move_busy      = (s_q.st != IDLE) && (s_q.st != DEL_WAIT);
endmodule // subscriber_modem_ctl
`default_nettype wire

// file: logic/headend_terminal_ctl.sv
// headend terminal end: flow delete and channel move control
`timescale 1ns/10ps
`default_nettype none
module headend_terminal_ctl
(
	input  wire logic                             clock,
	input  wire logic                             reset,
	chan_svc_if.headend                           link,
	input  wire logic                             registered,
	input  wire logic [chan_svc_pkg::FLOW_W-1:0]  owned_up,
	input  wire logic [chan_svc_pkg::FLOW_W-1:0]  owned_dn,
	input  wire logic                             del_valid,
	input  wire logic [chan_svc_pkg::FLOW_W-1:0]  del_up_flow,
	input  wire logic [chan_svc_pkg::FLOW_W-1:0]  del_dn_flow,
	input  wire logic                             move_valid,
	input  wire chan_svc_pkg::msg_s               move_req,
	input  wire logic [7:0]                       old_ucid,
	input  wire logic [7:0]                       new_ucid,
	input  wire logic [chan_svc_pkg::MS_W-1:0]    extra_ms,
	input  wire logic                             modem_seen_new,
	input  wire logic                             late_range,
	output logic                                  busy,
	output logic                                  flow_remove,
	output logic [chan_svc_pkg::FLOW_W-1:0]       flow_remove_up,
	output logic [chan_svc_pkg::FLOW_W-1:0]       flow_remove_dn,
	output logic                                  old_held,
	output logic                                  new_held,
	output logic                                  move_refused
);
	typedef struct packed {
		chan_svc_pkg::msg_s               out;
		logic                             out_v;
		logic                             wait_del;
		logic [chan_svc_pkg::TICK_W-1:0]  tick_cnt;
		logic [chan_svc_pkg::MS_W-1:0]    old_ms;
		logic [chan_svc_pkg::MS_W-1:0]    new_ms;
		logic                             rm;
		logic [chan_svc_pkg::FLOW_W-1:0]  rm_up;
		logic [chan_svc_pkg::FLOW_W-1:0]  rm_dn;
		logic                             refused;
	} state_s;

	state_s                        s_q;
	state_s                        s_d;
	logic                          tick;
	logic [chan_svc_pkg::MS_W:0]   hold_sum;

	always_comb
	begin
		s_d         = s_q;
		s_d.out_v   = 1'b0;
		s_d.rm      = 1'b0;
		s_d.refused = 1'b0;
		hold_sum    = '0;
		tick        = (s_q.tick_cnt == chan_svc_pkg::TICK_W'(chan_svc_pkg::TICK_CYCLES - 1));
		s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + 1'b1;
		if (tick && s_q.old_ms != '0)
			s_d.old_ms = s_q.old_ms - 1'b1;
		if (tick && s_q.new_ms != '0)
			s_d.new_ms = s_q.new_ms - 1'b1;
		if (modem_seen_new)
		begin
			s_d.old_ms = '0;
			s_d.new_ms = '0;
		end
		if (link.up_valid)
			case (link.up_msg.kind)
				chan_svc_pkg::MSG_DEL_REQ:
				begin
					// only flows the modem owns are removed
					s_d.rm      = 1'b1;
					s_d.rm_up   = (link.up_msg.up_flow == owned_up) ? owned_up : chan_svc_pkg::FLOW_NONE;
					s_d.rm_dn   = (link.up_msg.dn_flow == owned_dn) ? owned_dn : chan_svc_pkg::FLOW_NONE;
					s_d.out     = link.up_msg;
					s_d.out.kind = chan_svc_pkg::MSG_DEL_RSP;
					s_d.out_v   = 1'b1;
				end
				chan_svc_pkg::MSG_DEL_RSP:
					s_d.wait_del = 1'b0;
				// depart frees nothing and arrive is not awaited
				default: ;
			endcase
		if (!s_d.out_v && late_range && s_q.new_ms == '0)
		begin
			s_d.out      = '0;
			s_d.out.kind = chan_svc_pkg::MSG_RANGE_ABORT;
			s_d.out_v    = 1'b1;
		end
		else if (!s_d.out_v && del_valid && !s_q.wait_del)
		begin
			s_d.rm          = 1'b1;
			s_d.rm_up       = del_up_flow;
			s_d.rm_dn       = del_dn_flow;
			s_d.out         = '0;
			s_d.out.kind    = chan_svc_pkg::MSG_DEL_REQ;
			s_d.out.up_flow = del_up_flow;
			s_d.out.dn_flow = del_dn_flow;
			s_d.out_v       = 1'b1;
			s_d.wait_del    = 1'b1;
		end
		else if (!s_d.out_v && move_valid)
		begin
			if (!registered || old_ucid == new_ucid)
				s_d.refused = 1'b1;
			else
			begin
				s_d.out      = move_req;
				s_d.out.kind = chan_svc_pkg::MSG_MOVE_REQ;
				s_d.out_v    = 1'b1;
				s_d.old_ms   = chan_svc_pkg::MS_W'(chan_svc_pkg::OLD_HOLD_MS);
				// hold time: default jump plus policy extra, clamped
				hold_sum = (chan_svc_pkg::MS_W+1)'(chan_svc_pkg::JUMP_DEFAULT_MS) + extra_ms;
				if (hold_sum < (chan_svc_pkg::MS_W+1)'(chan_svc_pkg::NEW_HOLD_MIN_MS))
					hold_sum = (chan_svc_pkg::MS_W+1)'(chan_svc_pkg::NEW_HOLD_MIN_MS);
				if (hold_sum > (chan_svc_pkg::MS_W+1)'(chan_svc_pkg::NEW_HOLD_MAX_MS))
					hold_sum = (chan_svc_pkg::MS_W+1)'(chan_svc_pkg::NEW_HOLD_MAX_MS);
				if (move_req.tech_present && move_req.tech != chan_svc_pkg::INIT_REINIT)
					s_d.new_ms = hold_sum[chan_svc_pkg::MS_W-1:0];
				else
					s_d.new_ms = '0;
			end
		end
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign link.dn_msg    = s_q.out;
	assign link.dn_valid  = s_q.out_v;
	assign busy           = s_q.wait_del;
	assign flow_remove    = s_q.rm;
	assign flow_remove_up = s_q.rm_up;
	assign flow_remove_dn = s_q.rm_dn;
	assign old_held       = (s_q.old_ms != '0);
	assign new_held       = (s_q.new_ms != '0);
	assign move_refused   = s_q.refused;
endmodule // headend_terminal_ctl
`default_nettype wire

// file: testbench/chan_svc_chk.sv
// link checker between the modem and headend ends
`timescale 1ns/10ps
`default_nettype none
module chan_svc_chk
(
	input  wire logic               clock,
	input  wire logic               reset,
	input  wire chan_svc_pkg::msg_s up_msg,
	input  wire logic               up_valid,
	input  wire chan_svc_pkg::msg_s dn_msg,
	input  wire logic               dn_valid
);
	logic up_del, up_rsp, up_dep, up_arr, dn_del, dn_rsp, dn_mov, dn_reinit;
	logic reinit_pend_q;
	// decoded message strobes
	assign up_del = up_valid && up_msg.kind == chan_svc_pkg::MSG_DEL_REQ;
	assign up_rsp = up_valid && up_msg.kind == chan_svc_pkg::MSG_DEL_RSP;
	assign up_dep = up_valid && up_msg.kind == chan_svc_pkg::MSG_MOVE_DEPART;
	assign up_arr = up_valid && up_msg.kind == chan_svc_pkg::MSG_MOVE_ARRIVE;
	assign dn_del = dn_valid && dn_msg.kind == chan_svc_pkg::MSG_DEL_REQ;
	assign dn_rsp = dn_valid && dn_msg.kind == chan_svc_pkg::MSG_DEL_RSP;
	assign dn_mov = dn_valid && dn_msg.kind == chan_svc_pkg::MSG_MOVE_REQ;
	assign dn_reinit = dn_mov && (!dn_msg.tech_present
		|| dn_msg.tech == chan_svc_pkg::INIT_REINIT);
	// latest move kind; a later move overrides, so a stale arrive is judged by the later move
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			reinit_pend_q <= 1'b0;
		else if (dn_mov)
			reinit_pend_q <= dn_reinit;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	a_del_req_answered: assert property (up_del |-> ##[1:3] dn_rsp)
		else $error("delete request not answered");
	a_hd_del_answered: assert property (dn_del |-> ##[1:3] up_rsp)
		else $error("headend delete not answered");
	a_rsp_has_cause: assert property (up_rsp |->
		$past(dn_del) || $past(dn_del, 2) || $past(dn_del, 3))
		else $error("delete response without request");
	a_depart_prompt: assert property (dn_mov |-> ##[1:3] up_dep)
		else $error("no depart after move request");
	a_depart_single: assert property (up_dep |=> (!up_dep) [*4])
		else $error("depart repeated");
	a_no_arrive_reinit: assert property (up_arr |-> !reinit_pend_q)
		else $error("arrive sent after re-initialization");
	a_move_direction: assert property (dn_mov |->
		dn_msg.move_up || dn_msg.move_dn)
		else $error("move names no direction");
	a_up_kinds: assert property (up_valid |->
		up_del || up_rsp || up_dep || up_arr)
		else $error("bad upstream message kind");
	a_dn_kinds: assert property (dn_valid |-> dn_del || dn_rsp || dn_mov
		|| dn_msg.kind == chan_svc_pkg::MSG_RANGE_ABORT)
		else $error("bad downstream message kind");
endmodule // chan_svc_chk
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for both ends joined on the link
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
	logic               clock, reset, m_dv, m_ready, m_rm, m_done, sync_done;
	logic               tune_start, use_old, do_reinit, do_range, bw_void;
	logic               move_busy, registered, h_dv, move_valid, seen_new;
	logic               h_busy, h_rm, old_held, new_held, refused, tp, reinit;
	logic               late_range, rng;
	logic [15:0]        m_up, m_dn, m_rm_up, m_rm_dn, owned_up, owned_dn;
	logic [15:0]        h_up, h_dn, h_rm_up, h_rm_dn, extra;
	logic [31:0]        m_cap, h_cap;
	logic [7:0]         old_ucid, new_ucid;
	chan_svc_pkg::msg_s move_req, up_last;
	chan_svc_pkg::init_tech_e t;
	int                 ev[13], err_total, cmp_count, cyc, i;
	chan_svc_if link();
	subscriber_modem_ctl subscriber_modem_ctl_i (.clock(clock), .reset(reset),
		.link(link), .del_valid(m_dv), .del_ready(m_ready), .del_up_flow(m_up),
		.del_dn_flow(m_dn), .flow_remove(m_rm), .flow_remove_up(m_rm_up),
		.flow_remove_dn(m_rm_dn), .del_done(m_done), .sync_done(sync_done),
		.tune_start(tune_start), .use_old(use_old), .do_reinit(do_reinit),
		.do_range(do_range), .bw_void(bw_void), .move_busy(move_busy));
	headend_terminal_ctl headend_terminal_ctl_i (.clock(clock), .reset(reset),
		.link(link), .registered(registered), .owned_up(owned_up),
		.owned_dn(owned_dn), .del_valid(h_dv), .del_up_flow(h_up),
		.del_dn_flow(h_dn), .move_valid(move_valid), .move_req(move_req),
		.old_ucid(old_ucid), .new_ucid(new_ucid), .extra_ms(extra),
		.modem_seen_new(seen_new), .late_range(late_range), .busy(h_busy),
		.flow_remove(h_rm), .flow_remove_up(h_rm_up), .flow_remove_dn(h_rm_dn),
		.old_held(old_held), .new_held(new_held), .move_refused(refused));
	chan_svc_chk chan_svc_chk_i (.clock(clock), .reset(reset),
		.up_msg(link.up_msg), .up_valid(link.up_valid),
		.dn_msg(link.dn_msg), .dn_valid(link.dn_valid));
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// pulse counters and captures, so checks need not hit the exact cycle
	always @(posedge clock)
	begin
		ev[0] += m_rm;
		ev[1] += m_done;
		ev[2] += tune_start;
		ev[3] += do_reinit;
		ev[4] += do_range;
		ev[5] += bw_void;
		ev[6] += h_rm;
		ev[7] += refused;
		ev[8] += link.up_valid && link.up_msg.kind == chan_svc_pkg::MSG_MOVE_ARRIVE;
		ev[9] += link.up_valid && link.up_msg.kind == chan_svc_pkg::MSG_MOVE_DEPART;
		ev[10] += use_old;
		ev[11] += move_busy;
		ev[12] += link.dn_valid
			&& link.dn_msg.kind == chan_svc_pkg::MSG_RANGE_ABORT;
		if (link.up_valid) up_last <= link.up_msg;
		if (m_rm) m_cap <= {m_rm_up, m_rm_dn};
		if (h_rm) h_cap <= {h_rm_up, h_rm_dn};
		cyc++;
		if (cyc == 6000)
		begin
			err_total++;
			wrap_up();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic clr();
		foreach (ev[k]) ev[k] = 0;
	endtask
	// modem request held until the edge that takes it
	task automatic m_del(input logic [15:0] u, input logic [15:0] d);
		int k;
		m_up = u;
		m_dn = d;
		m_dv = 1'b1;
		for (k = 0; k < 20 && m_ready !== 1'b1; k++) tick(1);
		tick(1);
		m_dv = 1'b0;
		tick(8);
	endtask
	// headend request; one edge after busy is clear is enough
	task automatic h_del(input logic [15:0] u, input logic [15:0] d);
		int k;
		h_up = u;
		h_dn = d;
		h_dv = 1'b1;
		for (k = 0; k < 20 && h_busy !== 1'b0; k++) tick(1);
		tick(1);
		h_dv = 1'b0;
		tick(8);
	endtask
	// order a move, then report sync once the modem has jumped
	task automatic move(input logic p, input chan_svc_pkg::init_tech_e tt);
		int k;
		move_req = '0;
		move_req.kind = chan_svc_pkg::MSG_MOVE_REQ;
		move_req.move_up = 1'b1;
		move_req.move_dn = 1'b1;
		move_req.tech_present = p;
		move_req.tech = tt;
		clr();
		move_valid = 1'b1;
		tick(1);
		move_valid = 1'b0;
		for (k = 0; k < 20 && ev[2] == 0; k++) tick(1);
		tick(2);
		sync_done = 1'b1;
		tick(4);
		sync_done = 1'b0;
		tick(2);
	endtask
	task automatic wrap_up();
		if (err_total == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		{m_dv, sync_done, h_dv, move_valid, seen_new, late_range} = '0;
		{m_up, m_dn, h_up, h_dn, extra, move_req} = '0;
		registered = 1'b1;
		old_ucid = 8'h01;
		new_ucid = 8'h02;
		owned_up = 16'h0011;
		reset = 1'b1;
		tick(3);
		reset = 1'b0;
		// modem delete, owned and then foreign downstream flow
		for (i = 0; i < 2; i++)
		begin
			owned_dn = i ? 16'h0099 : 16'h0022;
			clr();
			m_del(16'h0011, 16'h0022);
			`CHK(ev[0], 1)
			`CHK(up_last.up_flow, 16'h0011)
			`CHK(h_cap, {16'h0011, i ? 16'h0000 : 16'h0022})
			`CHK(ev[1], 1)
		end
		clr();
		h_del(16'h0005, 16'h0006);
		`CHK(ev[6], 1)
		`CHK(m_cap, {16'h0005, 16'h0006})
		`CHK(up_last.kind, chan_svc_pkg::MSG_DEL_RSP)
		// refused: unregistered, then same upstream id
		for (i = 0; i < 2; i++)
		begin
			registered = i[0];
			new_ucid = i ? 8'h01 : 8'h02;
			move(1'b1, chan_svc_pkg::INIT_DIRECT);
			`CHK(ev[7], 1)
			`CHK(ev[9], 0)
			`CHK(ev[11], 0)
		end
		new_ucid = 8'h02;
		// each technique, then one with the field left out
		for (i = 0; i < 5; i++)
		begin
			t = chan_svc_pkg::init_tech_e'(i[1:0]);
			tp = i < 4;
			reinit = !tp || t == chan_svc_pkg::INIT_REINIT;
			rng = tp && t != chan_svc_pkg::INIT_REINIT
				&& t != chan_svc_pkg::INIT_DIRECT;
			// odd runs push the hold sum past 16 bits before the clamp
			extra = i[0] ? 16'hfaec : 16'h0000;
			move(tp, t);
			`CHK(ev[9], 1)
			`CHK(ev[2], 1)
			`CHK(ev[10], 2)
			`CHK(ev[11], 6)
			`CHK(ev[3], int'(reinit))
			`CHK(ev[8], int'(!reinit))
			`CHK(ev[4], int'(rng))
			`CHK(ev[5], 1)
			`CHK(old_held, 1'b1)
			`CHK(new_held, !reinit)
			seen_new = 1'b1;
			tick(3);
			`CHK(old_held, 1'b0)
			seen_new = 1'b0;
		end
		// late ranging draws an abort only once the new hold is over
		for (i = 0; i < 2; i++)
		begin
			if (i)
				move(1'b1, chan_svc_pkg::INIT_DIRECT);
			clr();
			late_range = 1'b1;
			tick(1);
			late_range = 1'b0;
			tick(2);
			`CHK(ev[12], int'(i == 0))
		end
		wrap_up();
	end
endmodule // testbench
`default_nettype wire
